/* File: shared/scss_pkg.sv */
// constants and types of the system clock source selector
// assumes a single 250 MHz bus clock; every clock source is sampled on it
package scss_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int DIV_W = 10;
	localparam int LOOP_INPUT_DIVIDE_FIELD_W = 4;
	localparam int LOOP_MULTIPLY_FIELD_W = 8;

	// register byte addresses
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_PRESC = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_LOOP = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0C;

	// control register fields
	localparam int CTRL_SEL_LSB = 0;
	localparam int CTRL_BYP_BIT = 2;
	localparam int CTRL_OSC_BIT = 3;
	// prescaler register field
	localparam int PRESC_K1_LSB = 0;
	// loop register fields
	localparam int LOOP_P_LSB = 0;
	localparam int LOOP_N_LSB = 8;
	localparam int LOOP_K2_LSB = 16;
	// status register fields
	localparam int STAT_SEL_LSB = 0;
	localparam int STAT_BYP_BIT = 2;
	localparam int STAT_OSC_BIT = 3;
	localparam int STAT_SWITCH_BIT = 4;
	localparam int STAT_CLK_BIT = 5;

	// clock source select codes
	localparam logic [1:0] SEL_WAKEUP = 2'h0;
	localparam logic [1:0] SEL_LOOP = 2'h2;
	localparam logic [1:0] SEL_DIRECT = 2'h3;

	// values after reset
	localparam logic [1:0] RST_SEL = SEL_WAKEUP;
	localparam logic RST_BYP = 1'b1;
	localparam logic RST_OSC = 1'b0;
	localparam logic [DIV_W-1:0] RST_K1 = 10'h000;
	localparam logic [LOOP_INPUT_DIVIDE_FIELD_W-1:0] RST_P = 4'h0;
	localparam logic [LOOP_MULTIPLY_FIELD_W-1:0] RST_N = 8'h00;
	localparam logic [DIV_W-1:0] RST_K2 = 10'h000;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [1:0] sel;
		logic byp;
		logic osc;
		logic [DIV_W-1:0] k1;
		logic [LOOP_INPUT_DIVIDE_FIELD_W-1:0] p;
		logic [LOOP_MULTIPLY_FIELD_W-1:0] n;
		logic [DIV_W-1:0] k2;
	} scss_cfg_t;

	localparam scss_cfg_t RST_CFG = '{sel: RST_SEL, byp: RST_BYP, osc: RST_OSC,
		k1: RST_K1, p: RST_P, n: RST_N, k2: RST_K2};

	typedef enum logic [1:0] {ST_RUN, ST_DRAIN, ST_HOLD, ST_LAUNCH} scss_state_t;

endpackage

/* File: shared/scss_div_if.sv */
// link between the selector and one of its edge-counting dividers
// assumes both ends run on the same bus clock
`timescale 1ns/1ps
interface scss_div_if;
	import scss_pkg::*;
	logic src;
	logic clear;
	logic [DIV_W-1:0] field;
	logic out;
	modport owner (output src, output clear, output field, input out);
	modport divider (input src, input clear, input field, output out);
endinterface

/* File: hw/scss_divider.sv */
// divides a sampled clock level by field+1, counting its half periods
// assumes src is already registered on aclk and field is stable while running
`timescale 1ns/1ps
module scss_divider (
	input wire logic aclk,
	input wire logic aresetn,
	scss_div_if.divider port_if
);
	import scss_pkg::*;

	logic src_q, src_d;
	logic out_q, out_d;
	logic [DIV_W-1:0] cnt_q, cnt_d;

	// toggling every field+1 source edges: factor one simply follows the source
	always_comb begin
		src_d = src_q;
		out_d = out_q;
		cnt_d = cnt_q;
		if (port_if.clear) begin
			src_d = port_if.src;
			// restart in phase with the source, else factor one inverts the duty
			out_d = port_if.src;
			cnt_d = '0;
		end else if (port_if.src != src_q) begin
			src_d = port_if.src;
			if (cnt_q == port_if.field) begin
				cnt_d = '0;
				out_d = ~out_q;
			end else begin
				cnt_d = cnt_q + 10'h001;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			src_q <= 1'b0;
			out_q <= 1'b0;
			cnt_q <= '0;
		end else begin
			src_q <= src_d;
			out_q <= out_d;
			cnt_q <= cnt_d;
		end
	end

	assign port_if.out = out_q;

endmodule // scss_divider

/* File: hw/scss_top.sv */
// system clock source selector with its AXI4-Lite register slave
// assumes every clock source input is synchronous to aclk and far slower than it
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps

// Notes on behaviour
// - select 11 takes clock from direct pin
// - direct mode keeps input duty cycle unshaped
// - select 10 with bypass runs prescaler
// - prescaler fed by crystal or internal oscillator
// - prescale factor is divide field plus one
// - factor one passes oscillator clock unchanged
// - prescale factors reach 1024
// - select 10 without bypass uses loop clock
// - loop P, N, K2 are fields plus one
// - select 00 runs from wakeup clock
module scss_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [scss_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [scss_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [scss_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [scss_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic direct_clock_input_pin,
	input wire logic crystal_input_pin,
	input wire logic internal_osc_clock,
	input wire logic wakeup_osc_clock,
	input wire logic vco_clock,
	output logic system_clock,
	output logic [scss_pkg::LOOP_INPUT_DIVIDE_FIELD_W:0] loop_input_factor,
	output logic [scss_pkg::LOOP_MULTIPLY_FIELD_W:0] loop_multiply_factor,
	output logic loop_ref_internal
);
	import scss_pkg::*;

	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
		input logic [DATA_W-1:0] new_v, input logic [3:0] strb);
		logic [DATA_W-1:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// bus side
	logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
	logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [DATA_W-1:0] rdata_q, rdata_d, wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic [ADDR_W-1:0] awaddr_q, awaddr_d;
	logic aw_have_q, aw_have_d, w_have_q, w_have_d;
	scss_cfg_t cfg_q, cfg_d;

	// clock side
	scss_cfg_t act_q, act_d;
	scss_state_t state_q, state_d;
	logic direct_q, xtal_q, intosc_q, wake_q, vco_q;
	logic sysclk_q, sysclk_d, clear_q, clear_d;
	logic [LOOP_INPUT_DIVIDE_FIELD_W:0] pfac_q, pfac_d;
	logic [LOOP_MULTIPLY_FIELD_W:0] nfac_q, nfac_d;
	logic ref_q, ref_d;
	logic mux_clk;

	scss_div_if presc_if ();
	scss_div_if post_if ();

	function automatic logic [DATA_W-1:0] reg_word(input logic [ADDR_W-1:0] a,
		input scss_cfg_t c, input scss_cfg_t act, input logic sw, input logic clk);
		logic [DATA_W-1:0] v;
		v = '0;
		unique case (a)
			ADDR_CTRL: begin
				v[CTRL_SEL_LSB +: 2] = c.sel;
				v[CTRL_BYP_BIT] = c.byp;
				v[CTRL_OSC_BIT] = c.osc;
			end
			ADDR_PRESC: v[PRESC_K1_LSB +: DIV_W] = c.k1;
			ADDR_LOOP: begin
				v[LOOP_P_LSB +: LOOP_INPUT_DIVIDE_FIELD_W] = c.p;
				v[LOOP_N_LSB +: LOOP_MULTIPLY_FIELD_W] = c.n;
				v[LOOP_K2_LSB +: DIV_W] = c.k2;
			end
			ADDR_STATUS: begin
				v[STAT_SEL_LSB +: 2] = act.sel;
				v[STAT_BYP_BIT] = act.byp;
				v[STAT_OSC_BIT] = act.osc;
				v[STAT_SWITCH_BIT] = sw;
				v[STAT_CLK_BIT] = clk;
			end
			default: v = '0;
		endcase
		return v;
	endfunction

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		return (a == ADDR_CTRL) || (a == ADDR_PRESC) || (a == ADDR_LOOP) || (a == ADDR_STATUS);
	endfunction

	// write address and data are taken independently, answered once both are in
	always_comb begin
		logic [DATA_W-1:0] word;
		word = '0;
		awready_d = awready_q;
		wready_d = wready_q;
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		cfg_d = cfg_q;
		if (s_axi_awvalid && awready_q) begin
			awaddr_d = s_axi_awaddr;
			aw_have_d = 1'b1;
			awready_d = 1'b0;
		end
		if (s_axi_wvalid && wready_q) begin
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
			w_have_d = 1'b1;
			wready_d = 1'b0;
		end
		if (aw_have_q && w_have_q && !bvalid_q) begin
			word = merge(reg_word(awaddr_q, cfg_q, act_q, 1'b0, 1'b0), wdata_q, wstrb_q);
			bvalid_d = 1'b1;
			bresp_d = mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			unique case (awaddr_q)
				ADDR_CTRL: begin
					cfg_d.sel = word[CTRL_SEL_LSB +: 2];
					cfg_d.byp = word[CTRL_BYP_BIT];
					cfg_d.osc = word[CTRL_OSC_BIT];
				end
				ADDR_PRESC: cfg_d.k1 = word[PRESC_K1_LSB +: DIV_W];
				ADDR_LOOP: begin
					cfg_d.p = word[LOOP_P_LSB +: LOOP_INPUT_DIVIDE_FIELD_W];
					cfg_d.n = word[LOOP_N_LSB +: LOOP_MULTIPLY_FIELD_W];
					cfg_d.k2 = word[LOOP_K2_LSB +: DIV_W];
				end
				default: ;
			endcase
		end
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
			awready_d = 1'b1;
			wready_d = 1'b1;
		end
	end

	// reads: one cycle from address to data
	always_comb begin
		arready_d = arready_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (s_axi_arvalid && arready_q) begin
			arready_d = 1'b0;
			rvalid_d = 1'b1;
			rdata_d = reg_word(s_axi_araddr, cfg_q, act_q, state_q != ST_RUN, sysclk_q);
			rresp_d = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
			arready_d = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			arready_q <= 1'b1;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
			cfg_q <= RST_CFG;
		end else begin
			awready_q <= awready_d;
			wready_q <= wready_d;
			arready_q <= arready_d;
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			cfg_q <= cfg_d;
		end
	end

	// sources are synchronous inputs: one register each, no synchroniser
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			direct_q <= 1'b0;
			xtal_q <= 1'b0;
			intosc_q <= 1'b0;
			wake_q <= 1'b0;
			vco_q <= 1'b0;
		end else begin
			direct_q <= direct_clock_input_pin;
			xtal_q <= crystal_input_pin;
			intosc_q <= internal_osc_clock;
			wake_q <= wakeup_osc_clock;
			vco_q <= vco_clock;
		end
	end

	assign presc_if.src = act_q.osc ? intosc_q : xtal_q;
	assign presc_if.field = act_q.k1;
	assign presc_if.clear = clear_q;
	assign post_if.src = vco_q;
	assign post_if.field = act_q.k2;
	assign post_if.clear = clear_q;

	scss_divider u_presc (
		.aclk(aclk),
		.aresetn(aresetn),
		.port_if(presc_if.divider)
	);

	scss_divider u_post (
		.aclk(aclk),
		.aresetn(aresetn),
		.port_if(post_if.divider)
	);

	// unused code 01 falls back to the wakeup source
	always_comb begin
		unique case (act_q.sel)
			SEL_DIRECT: mux_clk = direct_q;
			SEL_LOOP: mux_clk = act_q.byp ? presc_if.out : post_if.out;
			default: mux_clk = wake_q;
		endcase
	end

	// a stopped old source held high would stall the switch in drain
	always_comb begin
		state_d = state_q;
		act_d = act_q;
		clear_d = 1'b0;
		sysclk_d = mux_clk;
		unique case (state_q)
			ST_RUN: begin
				if (cfg_q != act_q) begin
					state_d = ST_DRAIN;
				end
			end
			ST_DRAIN: begin
				if (!sysclk_q) begin
					sysclk_d = 1'b0;
					state_d = ST_HOLD;
				end
			end
			ST_HOLD: begin
				sysclk_d = 1'b0;
				act_d = cfg_q;
				clear_d = 1'b1;
				state_d = ST_LAUNCH;
			end
			ST_LAUNCH: begin
				sysclk_d = 1'b0;
				if (!clear_q && !mux_clk) begin
					state_d = ST_RUN;
				end
			end
		endcase
		pfac_d = {1'b0, act_d.p} + 5'h01;
		nfac_d = {1'b0, act_d.n} + 9'h001;
		ref_d = act_d.osc;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= ST_RUN;
			act_q <= RST_CFG;
			clear_q <= 1'b0;
			sysclk_q <= 1'b0;
			pfac_q <= 5'h01;
			nfac_q <= 9'h001;
			ref_q <= RST_OSC;
		end else begin
			state_q <= state_d;
			act_q <= act_d;
			clear_q <= clear_d;
			sysclk_q <= sysclk_d;
			pfac_q <= pfac_d;
			nfac_q <= nfac_d;
			ref_q <= ref_d;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign system_clock = sysclk_q;
	assign loop_input_factor = pfac_q;
	assign loop_multiply_factor = nfac_q;
	assign loop_ref_internal = ref_q;

endmodule // scss_top

/* File: testbench/scss_top_props.sv */
// port assertions for the clock source selector
// assumes sources toggle no faster than every 2 aclk cycles
`timescale 1ns/1ps
module scss_top_props
	import scss_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [scss_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [scss_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic direct_clock_input_pin,
	input wire logic wakeup_osc_clock,
	input wire logic system_clock,
	input wire logic [scss_pkg::LOOP_INPUT_DIVIDE_FIELD_W:0] loop_input_factor,
	input wire logic [scss_pkg::LOOP_MULTIPLY_FIELD_W:0] loop_multiply_factor,
	input wire logic loop_ref_internal
);
	logic [ADDR_W-1:0] aw_q;
	logic [3:0] w_q;
	logic [3:0] ctrl_q;
	logic [12:0] cnt_q;
	logic bv_q;
	logic settled;
	// long settle window covers the slowest drain of a 1024 divider
	assign settled = cnt_q == 13'h1FFF;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= {RST_OSC, RST_BYP, RST_SEL};
			cnt_q <= 13'h0000;
			bv_q <= 1'b0;
		end else begin
			bv_q <= s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready) w_q <= s_axi_wdata[3:0];
			if (s_axi_bvalid && !bv_q) begin
				cnt_q <= 13'h0000;
				if (aw_q == ADDR_CTRL) ctrl_q <= w_q;
			end else if (!settled) begin
				cnt_q <= cnt_q + 13'h0001;
			end
		end
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	high_phase_a: assert property ($rose(system_clock) |=> system_clock)
		else $error("system clock high phase cut short");
	low_phase_a: assert property ($fell(system_clock) |=> !system_clock)
		else $error("system clock low phase cut short");
	direct_path_a: assert property (settled && ctrl_q[1:0] == SEL_DIRECT
		|-> system_clock == $past(direct_clock_input_pin, 2)) else $error("direct path wrong");
	wakeup_path_a: assert property (settled && ctrl_q[1:0] == SEL_WAKEUP
		|-> system_clock == $past(wakeup_osc_clock, 2)) else $error("wakeup path wrong");
	ref_select_a: assert property (settled |-> loop_ref_internal == ctrl_q[3])
		else $error("reference choice wrong");
	loop_p_a: assert property (loop_input_factor != 5'h00 && loop_input_factor <= 5'h10)
		else $error("loop input factor out of range");
	loop_n_a: assert property (loop_multiply_factor != 9'h000 && loop_multiply_factor <= 9'h100)
		else $error("loop multiply factor out of range");
	resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
endmodule // scss_top_props

bind scss_top scss_top_props u_props (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .direct_clock_input_pin, .wakeup_osc_clock, .system_clock,
	.loop_input_factor, .loop_multiply_factor, .loop_ref_internal);

/* File: testbench/scss_src_model.sv */
// free-running clock sources seen by the selector
// assumes one aclk; levels change by nonblocking assignment on it
`timescale 1ns/1ps
module scss_osc_gen #(
	parameter int HI = 2,
	parameter int LO = 2
) (
	input wire logic aclk,
	output logic level
);
	int cnt_q = 0;
	initial level = 1'b0;
	always @(posedge aclk) begin
		cnt_q <= (cnt_q == HI + LO - 1) ? 0 : cnt_q + 1;
		level <= cnt_q < HI;
	end
endmodule // scss_osc_gen

module scss_src_model (
	input wire logic aclk,
	output logic direct_clock_input_pin,
	output logic crystal_input_pin,
	output logic internal_osc_clock,
	output logic wakeup_osc_clock,
	output logic vco_clock
);
	// uneven duties on the direct and internal oscillator sources so a reshaped path shows up in the phase counts
	scss_osc_gen #(.HI(3), .LO(5)) u_dir (.aclk(aclk), .level(direct_clock_input_pin));
	scss_osc_gen #(.HI(4), .LO(4)) u_xtl (.aclk(aclk), .level(crystal_input_pin));
	scss_osc_gen #(.HI(2), .LO(6)) u_int (.aclk(aclk), .level(internal_osc_clock));
	scss_osc_gen #(.HI(6), .LO(6)) u_wu (.aclk(aclk), .level(wakeup_osc_clock));
	scss_osc_gen #(.HI(2), .LO(2)) u_vco (.aclk(aclk), .level(vco_clock));
endmodule // scss_src_model

/* File: testbench/tb.sv */
// self-checking bench of the clock source selector
// assumes the source phases set in scss_src_model
`timescale 1ns/1ps
module tb;
	import scss_pkg::*;
	typedef struct {
		logic [31:0] ctrl;
		logic [31:0] presc;
		logic [31:0] loopw;
		int hi;
		int lo;
	} scss_row_t;
	localparam int LIMIT = 60000;
	scss_row_t rows [9] = '{
		'{32'h3, 32'h0, 32'h0, 3, 5},
		'{32'h0, 32'h0, 32'h0, 6, 6},
		'{32'h1, 32'h0, 32'h0, 6, 6},
		'{32'h6, 32'h0, 32'h0, 4, 4},
		'{32'hE, 32'h0, 32'h0, 2, 6},
		'{32'h6, 32'h2, 32'h0, 12, 12},
		'{32'hE, 32'h1, 32'h0, 8, 8},
		'{32'h2, 32'h0, 32'h11F03, 4, 4},
		'{32'h6, 32'h3FF, 32'h0, 4096, 4096}};
	logic aclk;
	logic aresetn;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic direct_clock_input_pin, crystal_input_pin, internal_osc_clock;
	logic wakeup_osc_clock, vco_clock, system_clock, loop_ref_internal;
	logic [LOOP_INPUT_DIVIDE_FIELD_W:0] loop_input_factor;
	logic [LOOP_MULTIPLY_FIELD_W:0] loop_multiply_factor;
	int failures = 0, cmp_count = 0, cycles = 0;
	scss_src_model u_src (.aclk, .direct_clock_input_pin, .crystal_input_pin,
		.internal_osc_clock, .wakeup_osc_clock, .vco_clock);
	scss_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .direct_clock_input_pin,
		.crystal_input_pin, .internal_osc_clock, .wakeup_osc_clock, .vco_clock, .system_clock,
		.loop_input_factor, .loop_multiply_factor, .loop_ref_internal);
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	always @(posedge aclk) begin
		cycles++;
		if (cycles == LIMIT) begin
			failures++;
			wrap_up();
		end
	end
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	// both bus tasks start one edge late so no signal is assigned twice in a step
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic run_row(input scss_row_t w);
		logic [1:0] r;
		logic [31:0] st;
		int hi;
		int lo;
		axi_write(ADDR_CTRL, w.ctrl, r);
		axi_write(ADDR_PRESC, w.presc, r);
		axi_write(ADDR_LOOP, w.loopw, r);
		repeat (4) @(posedge aclk);
		st = 32'h10;
		while (st[STAT_SWITCH_BIT]) axi_read(ADDR_STATUS, st, r);
		check("status cfg", w.ctrl[3:0], st[3:0]);
		check("ref internal", w.ctrl[3], loop_ref_internal);
		check("loop p", w.loopw[3:0] + 1, loop_input_factor);
		check("loop n", w.loopw[15:8] + 1, loop_multiply_factor);
		while (system_clock !== 1'b0) @(posedge aclk);
		while (system_clock !== 1'b1) @(posedge aclk);
		hi = 0;
		lo = 0;
		while (system_clock === 1'b1) begin
			hi++;
			@(posedge aclk);
		end
		while (system_clock === 1'b0) begin
			lo++;
			@(posedge aclk);
		end
		check("high cycles", w.hi, hi);
		check("low cycles", w.lo, lo);
		// dwell lets the settled path assertions engage
		if (w.ctrl[1] == w.ctrl[0]) repeat (8300) @(posedge aclk);
		$display("test cfg %h done", w.ctrl);
	endtask
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		aresetn <= 1'b0;
		s_axi_awaddr <= 8'h00;
		s_axi_araddr <= 8'h00;
		s_axi_wdata <= 32'h0;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		s_axi_bready <= 1'b0;
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rows[i]) run_row(rows[i]);
		aresetn <= 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		check("clock after reset", 32'h0, system_clock);
		check("p after reset", 32'h1, loop_input_factor);
		check("n after reset", 32'h1, loop_multiply_factor);
		axi_read(ADDR_CTRL, d, r);
		check("ctrl reset", {RST_OSC, RST_BYP, RST_SEL}, d);
		axi_read(ADDR_LOOP, d, r);
		check("loop reset", 32'h0, d);
		axi_read(8'h10, d, r);
		check("unmapped read resp", RESP_SLVERR, r);
		check("unmapped read data", 32'h0, d);
		axi_write(8'h14, 32'h3, r);
		check("unmapped write resp", RESP_SLVERR, r);
		axi_write(ADDR_STATUS, 32'h3, r);
		check("status write resp", RESP_OKAY, r);
		axi_read(ADDR_CTRL, d, r);
		check("ctrl untouched", {RST_OSC, RST_BYP, RST_SEL}, d);
		// only byte one lands: the multiply field, the rest keeps its old value
		s_axi_wstrb <= 4'h2;
		axi_write(ADDR_LOOP, 32'hAAAA55AA, r);
		s_axi_wstrb <= 4'hF;
		axi_read(ADDR_LOOP, d, r);
		check("loop strobed", 32'h00005500, d);
		repeat (4) @(posedge aclk);
		d = 32'h10;
		while (d[STAT_SWITCH_BIT]) axi_read(ADDR_STATUS, d, r);
		check("n strobed", 32'h56, loop_multiply_factor);
		$display("test byte strobes done");
		$display("test reset and refusals done");
		wrap_up();
	end
endmodule // tb
